// [ctrb_trim_bank.sv]
// Converter trim register bank: offset and fine gain trims, loaded from fuses after reset.
// Assumes fuse values are stable at reset release and the configuration port master obeys
// the access windows around offset calibration.
//
// Notes on behaviour
// RULE1: Core 2 input B offset trim, bits 11:0, applied while core 2 samples input B.
// RULE2: Offset trim at 0x338 applied to core 3 while sampling input C.
// RULE3: Separate offset trim at 0x33a applied to core 3 while sampling input D.
// RULE4: Offset trim at 0x33c always applied to core 4.
// RULE5: Offset trim at 0x33e always applied to core 5.
// RULE6: Software writes zero into unused upper bits; those bits stay readable and writable.
// RULE7: Fine gain trim bits 4:0 at 0x360 applied to core 0.
// RULE8: Fine gain trim bits 4:0 at 0x361 applied to core 1.
// RULE9: Fine gain trim at 0x362 applied to core 2 only while sampling input A.
// RULE10: After reset each trim field loads its fuse default, not a constant.
// RULE11: Offset trims are unsigned binary when applied to cores.
// RULE12: Software avoids offset registers while offset calibration runs.
// RULE13: Trim sets follow the input routed to a two-input core, switching together; here trims switch one edge after the routing select.
`timescale 1ns/1ps

module ctrb_trim_bank (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // Configuration port
  input wire logic [11:0] addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [15:0] rdata_out,
  // Fuse defaults
  input wire ctrb_pkg::ctrb_ofs_set_s fuse_ofs_in,
  input wire ctrb_pkg::ctrb_gain_set_s fuse_gain_in,
  // Input routing: high selects input B on core 2, input D on core 3
  input wire logic core2_sel_b_in,
  input wire logic core3_sel_d_in,
  // Trims to cores
  output logic [11:0] core2_offset_out,
  output logic [11:0] core3_offset_out,
  output logic [11:0] core4_offset_out,
  output logic [11:0] core5_offset_out,
  output logic [4:0] core0_gain_out,
  output logic [4:0] core1_gain_out,
  output logic [4:0] core2_gain_out,
  output logic core2_gain_en_out,
  output logic trims_valid_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Register state

  ctrb_pkg::ctrb_bus_req_s req;
  ctrb_pkg::ctrb_state_e state_reg, state_next;
  ctrb_pkg::ctrb_ofs_set_s ofs_reg, ofs_next;
  ctrb_pkg::ctrb_gain_set_s gain_reg, gain_next;
  logic [3:0] ofs_rsv_reg [5];
  logic [3:0] ofs_rsv_next [5];
  logic [2:0] gain_rsv_reg [3];
  logic [2:0] gain_rsv_next [3];
  logic [15:0] rdata_reg, rdata_next;

  assign req = '{addr: addr_in, wdata: wdata_in, wr: wr_in, rd: rd_in};

  // Offset register index from address, 5 when unmapped
  function automatic logic [2:0] ofs_index(input logic [11:0] a);
    unique case (a)
      ctrb_pkg::CORE2_INPUT_B_OFFSET_TRIM_ADDR: ofs_index = 3'h0;
      ctrb_pkg::CORE3_INPUT_C_OFFSET_TRIM_ADDR: ofs_index = 3'h1;
      ctrb_pkg::CORE3_INPUT_D_OFFSET_TRIM_ADDR: ofs_index = 3'h2;
      ctrb_pkg::CORE4_OFFSET_TRIM_ADDR: ofs_index = 3'h3;
      ctrb_pkg::CORE5_OFFSET_TRIM_ADDR: ofs_index = 3'h4;
      default: ofs_index = 3'h5;
    endcase
  endfunction

  // Gain register index from address, 3 when unmapped
  function automatic logic [1:0] gain_index(input logic [11:0] a);
    unique case (a)
      ctrb_pkg::CORE0_FINE_TRIM_ADDR: gain_index = 2'h0;
      ctrb_pkg::CORE1_FINE_TRIM_ADDR: gain_index = 2'h1;
      ctrb_pkg::CORE2_INPUT_A_FINE_TRIM_ADDR: gain_index = 2'h2;
      default: gain_index = 2'h3;
    endcase
  endfunction

  logic [11:0] ofs_fields [5];
  logic [4:0] gain_fields [3];
  assign ofs_fields[0] = ofs_reg.core2_b;
  assign ofs_fields[1] = ofs_reg.core3_c;
  assign ofs_fields[2] = ofs_reg.core3_d;
  assign ofs_fields[3] = ofs_reg.core4;
  assign ofs_fields[4] = ofs_reg.core5;
  assign gain_fields[0] = gain_reg.core0;
  assign gain_fields[1] = gain_reg.core1;
  assign gain_fields[2] = gain_reg.core2_a;

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb begin
    logic [2:0] oi;
    logic [1:0] gi;
    oi = ofs_index(req.addr);
    gi = gain_index(req.addr);
    state_next = ctrb_pkg::CTRB_RUN;
    ofs_next = ofs_reg;
    gain_next = gain_reg;
    ofs_rsv_next = ofs_rsv_reg;
    gain_rsv_next = gain_rsv_reg;
    rdata_next = 16'h0000;
    unique case (state_reg)
      ctrb_pkg::CTRB_LOAD: begin
        // Fuse values only sampled after release, never under reset
        ofs_next = fuse_ofs_in; // RULE10
        gain_next = fuse_gain_in; // RULE10
      end
      ctrb_pkg::CTRB_RUN: begin
        if (req.wr && oi != 3'h5) begin
          ofs_rsv_next[oi] = req.wdata[ctrb_pkg::OFS_RSV_MSB:ctrb_pkg::OFS_RSV_LSB]; // RULE6
          unique case (oi)
            3'h0: ofs_next.core2_b = req.wdata[ctrb_pkg::OFS_MSB:ctrb_pkg::OFS_LSB]; // RULE1
            3'h1: ofs_next.core3_c = req.wdata[ctrb_pkg::OFS_MSB:ctrb_pkg::OFS_LSB]; // RULE2
            3'h2: ofs_next.core3_d = req.wdata[ctrb_pkg::OFS_MSB:ctrb_pkg::OFS_LSB]; // RULE3
            3'h3: ofs_next.core4 = req.wdata[ctrb_pkg::OFS_MSB:ctrb_pkg::OFS_LSB]; // RULE4
            default: ofs_next.core5 = req.wdata[ctrb_pkg::OFS_MSB:ctrb_pkg::OFS_LSB]; // RULE5
          endcase
        end
        if (req.wr && gi != 2'h3) begin
          gain_rsv_next[gi] = req.wdata[ctrb_pkg::GAIN_RSV_MSB:ctrb_pkg::GAIN_RSV_LSB]; // RULE6
          unique case (gi)
            2'h0: gain_next.core0 = req.wdata[ctrb_pkg::GAIN_MSB:ctrb_pkg::GAIN_LSB]; // RULE7
            2'h1: gain_next.core1 = req.wdata[ctrb_pkg::GAIN_MSB:ctrb_pkg::GAIN_LSB]; // RULE8
            default: gain_next.core2_a = req.wdata[ctrb_pkg::GAIN_MSB:ctrb_pkg::GAIN_LSB]; // RULE9
          endcase
        end
        // Unmapped reads return zero
        if (req.rd && oi != 3'h5) begin
          rdata_next = {ofs_rsv_reg[oi], ofs_fields[oi]}; // RULE6
        end else if (req.rd && gi != 2'h3) begin
          rdata_next = {8'h00, gain_rsv_reg[gi], gain_fields[gi]}; // RULE6
        end
      end
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      state_reg <= ctrb_pkg::CTRB_LOAD;
      ofs_reg <= '0;
      gain_reg <= '0;
      for (int i = 0; i < 5; i++) begin
        ofs_rsv_reg[i] <= ctrb_pkg::OFS_RSV_RESET;
      end
      for (int i = 0; i < 3; i++) begin
        gain_rsv_reg[i] <= ctrb_pkg::GAIN_RSV_RESET;
      end
      rdata_reg <= 16'h0000;
    end else begin
      state_reg <= state_next;
      ofs_reg <= ofs_next;
      gain_reg <= gain_next;
      ofs_rsv_reg <= ofs_rsv_next;
      gain_rsv_reg <= gain_rsv_next;
      rdata_reg <= rdata_next;
    end
  end

  assign rdata_out = rdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Trim outputs, registered, so trims switch one edge after the input switch

  logic [11:0] c2_ofs_reg, c2_ofs_next, c3_ofs_reg, c3_ofs_next;
  logic [11:0] c4_ofs_reg, c4_ofs_next, c5_ofs_reg, c5_ofs_next;
  logic [4:0] g0_reg, g0_next, g1_reg, g1_next, g2_reg, g2_next;
  logic g2_en_reg, g2_en_next, valid_reg, valid_next;

  always_comb begin
    // Core 2 input A offset lives outside this bank; zero trim here
    c2_ofs_next = core2_sel_b_in ? ofs_reg.core2_b : 12'h000; // RULE1 RULE13
    c3_ofs_next = core3_sel_d_in ? ofs_reg.core3_d : ofs_reg.core3_c; // RULE2 RULE3 RULE13
    c4_ofs_next = ofs_reg.core4; // RULE4 RULE11
    c5_ofs_next = ofs_reg.core5; // RULE5 RULE11
    g0_next = gain_reg.core0; // RULE7
    g1_next = gain_reg.core1; // RULE8
    g2_next = core2_sel_b_in ? 5'h00 : gain_reg.core2_a; // RULE9 RULE13
    g2_en_next = !core2_sel_b_in; // RULE9
    valid_next = (state_reg == ctrb_pkg::CTRB_RUN);
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      c2_ofs_reg <= 12'h000;
      c3_ofs_reg <= 12'h000;
      c4_ofs_reg <= 12'h000;
      c5_ofs_reg <= 12'h000;
      g0_reg <= 5'h00;
      g1_reg <= 5'h00;
      g2_reg <= 5'h00;
      g2_en_reg <= 1'b0;
      valid_reg <= 1'b0;
    end else begin
      c2_ofs_reg <= c2_ofs_next;
      c3_ofs_reg <= c3_ofs_next;
      c4_ofs_reg <= c4_ofs_next;
      c5_ofs_reg <= c5_ofs_next;
      g0_reg <= g0_next;
      g1_reg <= g1_next;
      g2_reg <= g2_next;
      g2_en_reg <= g2_en_next;
      valid_reg <= valid_next;
    end
  end

  assign core2_offset_out = c2_ofs_reg;
  assign core3_offset_out = c3_ofs_reg;
  assign core4_offset_out = c4_ofs_reg;
  assign core5_offset_out = c5_ofs_reg;
  assign core0_gain_out = g0_reg;
  assign core1_gain_out = g1_reg;
  assign core2_gain_out = g2_reg;
  assign core2_gain_en_out = g2_en_reg;
  assign trims_valid_out = valid_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  sequence wr_at(logic [11:0] a);
    wr_in && !rd_in && addr_in == a && state_reg == ctrb_pkg::CTRB_RUN;
  endsequence

  sequence rd_at(logic [11:0] a);
    rd_in && !wr_in && addr_in == a;
  endsequence

  // Release edge, which loads the fuses, then the edge that registers the trims to the outputs
  sequence load_done;
    $fell(rst_in) ##1 1'b1;
  endsequence

  fuse_load_a: assert property (@(posedge core_clk_in) // RULE10
    $fell(rst_in) |=> ofs_reg == $past(fuse_ofs_in) && gain_reg == $past(fuse_gain_in))
    else $error("fuse defaults not loaded after reset");

  core4_write_a: assert property (@(posedge core_clk_in) disable iff (rst_in) // RULE4
    wr_at(ctrb_pkg::CORE4_OFFSET_TRIM_ADDR) |=> ##1 core4_offset_out == $past(wdata_in[11:0], 2))
    else $error("core 4 offset not applied");

  core5_write_a: assert property (@(posedge core_clk_in) disable iff (rst_in) // RULE5
    wr_at(ctrb_pkg::CORE5_OFFSET_TRIM_ADDR) |=> ##1 core5_offset_out == $past(wdata_in[11:0], 2))
    else $error("core 5 offset not applied");

  core3_sel_a: assert property (@(posedge core_clk_in) disable iff (rst_in) // RULE13
    core3_sel_d_in |=> core3_offset_out == $past(ofs_reg.core3_d))
    else $error("core 3 input D trim not selected");

  core3_c_sel_a: assert property (@(posedge core_clk_in) disable iff (rst_in) // RULE2
    !core3_sel_d_in |=> core3_offset_out == $past(ofs_reg.core3_c))
    else $error("core 3 input C trim not selected");

  core2_b_a: assert property (@(posedge core_clk_in) disable iff (rst_in) // RULE1
    core2_sel_b_in |=> core2_offset_out == $past(ofs_reg.core2_b) && !core2_gain_en_out)
    else $error("core 2 input B trim wrong");

  core2_gain_a: assert property (@(posedge core_clk_in) disable iff (rst_in) // RULE9
    !core2_sel_b_in |=> core2_gain_out == $past(gain_reg.core2_a) && core2_gain_en_out)
    else $error("core 2 input A gain wrong");

  core0_fine_trim_rdback_a: assert property (@(posedge core_clk_in) disable iff (rst_in) // RULE7
    wr_at(ctrb_pkg::CORE0_FINE_TRIM_ADDR) ##1 rd_at(ctrb_pkg::CORE0_FINE_TRIM_ADDR)
    |=> rdata_out == {8'h00, $past(wdata_in[7:0], 2)})
    else $error("core 0 gain readback wrong");

  core1_fine_trim_out_a: assert property (@(posedge core_clk_in) disable iff (rst_in) // RULE8
    wr_at(ctrb_pkg::CORE1_FINE_TRIM_ADDR) |=> ##1 core1_gain_out == $past(wdata_in[4:0], 2))
    else $error("core 1 gain not applied");

  rsv_rdback_a: assert property (@(posedge core_clk_in) disable iff (rst_in) // RULE6
    wr_at(ctrb_pkg::CORE3_INPUT_D_OFFSET_TRIM_ADDR) ##1 rd_at(ctrb_pkg::CORE3_INPUT_D_OFFSET_TRIM_ADDR)
    |=> rdata_out == $past(wdata_in, 2))
    else $error("offset register readback wrong");

  ////////////////////////////////////////////////////////////////////////////
  // Checks: reset and fuse load

  // Cores must never see a stale trim while reset holds
  reset_clear_a: assert property (@(posedge core_clk_in) // RULE10
    rst_in |=> rdata_out == 16'h0000 && !trims_valid_out && !core2_gain_en_out &&
      core2_offset_out == 12'h000 && core3_offset_out == 12'h000 &&
      core4_offset_out == 12'h000 && core5_offset_out == 12'h000 &&
      core0_gain_out == 5'h00 && core1_gain_out == 5'h00 && core2_gain_out == 5'h00)
    else $error("outputs not cleared by reset");

  fuse_valid_a: assert property (@(posedge core_clk_in) disable iff (rst_in) // RULE10
    $fell(rst_in) |=> !trims_valid_out ##1 trims_valid_out)
    else $error("trims valid flag out of step with fuse load");

  // Trims reach the cores one edge after the load edge
  fuse_out_a: assert property (@(posedge core_clk_in) disable iff (rst_in) // RULE10
    load_done |=> core4_offset_out == $past(fuse_ofs_in.core4, 2) &&
      core5_offset_out == $past(fuse_ofs_in.core5, 2) &&
      core0_gain_out == $past(fuse_gain_in.core0, 2) && core1_gain_out == $past(fuse_gain_in.core1, 2))
    else $error("fuse defaults not applied to cores");

  ////////////////////////////////////////////////////////////////////////////
  // Checks: writes reach the selected core

  core0_write_a: assert property (@(posedge core_clk_in) disable iff (rst_in) // RULE7
    wr_at(ctrb_pkg::CORE0_FINE_TRIM_ADDR) |=> ##1 core0_gain_out == $past(wdata_in[4:0], 2))
    else $error("core 0 gain not applied");

  core2_a_write_a: assert property (@(posedge core_clk_in) disable iff (rst_in) // RULE9
    wr_at(ctrb_pkg::CORE2_INPUT_A_FINE_TRIM_ADDR) ##1 !core2_sel_b_in
    |=> core2_gain_out == $past(wdata_in[4:0], 2))
    else $error("core 2 input A gain not applied");

  core2_b_write_a: assert property (@(posedge core_clk_in) disable iff (rst_in) // RULE1
    wr_at(ctrb_pkg::CORE2_INPUT_B_OFFSET_TRIM_ADDR) ##1 core2_sel_b_in
    |=> core2_offset_out == $past(wdata_in[11:0], 2))
    else $error("core 2 input B offset not applied");

  core3_c_write_a: assert property (@(posedge core_clk_in) disable iff (rst_in) // RULE2
    wr_at(ctrb_pkg::CORE3_INPUT_C_OFFSET_TRIM_ADDR) ##1 !core3_sel_d_in
    |=> core3_offset_out == $past(wdata_in[11:0], 2))
    else $error("core 3 input C offset not applied");

  core3_d_write_a: assert property (@(posedge core_clk_in) disable iff (rst_in) // RULE3
    wr_at(ctrb_pkg::CORE3_INPUT_D_OFFSET_TRIM_ADDR) ##1 core3_sel_d_in
    |=> core3_offset_out == $past(wdata_in[11:0], 2))
    else $error("core 3 input D offset not applied");

  ////////////////////////////////////////////////////////////////////////////
  // Checks: routing

  // Trims of the other input live outside this bank, so they read as zero here
  ofs_a_zero_a: assert property (@(posedge core_clk_in) disable iff (rst_in) // RULE13
    !core2_sel_b_in |=> core2_offset_out == 12'h000)
    else $error("core 2 input B offset leaked to input A");

  gain_b_zero_a: assert property (@(posedge core_clk_in) disable iff (rst_in) // RULE13
    core2_sel_b_in |=> core2_gain_out == 5'h00 && !core2_gain_en_out)
    else $error("core 2 input A gain leaked to input B");

  ////////////////////////////////////////////////////////////////////////////
  // Checks: readback

  rdata_idle_a: assert property (@(posedge core_clk_in) disable iff (rst_in) // RULE6
    !rd_in |=> rdata_out == 16'h0000)
    else $error("read data stand longer than one cycle");

  unmapped_rd_a: assert property (@(posedge core_clk_in) disable iff (rst_in) // RULE6
    rd_in && ofs_index(addr_in) == 3'h5 && gain_index(addr_in) == 2'h3 |=> rdata_out == 16'h0000)
    else $error("unmapped read not zero");

  gain_upper_a: assert property (@(posedge core_clk_in) disable iff (rst_in) // RULE6
    rd_in && gain_index(addr_in) != 2'h3 |=> rdata_out[15:8] == 8'h00)
    else $error("gain readback upper byte not zero");

endmodule

// [ctrb_pkg.sv]
// Package for the converter trim register bank: offsets, field layout, reset values.
// Assumes a 12-bit byte address space for the configuration port.
package ctrb_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 16;
  localparam int OFS_W = 12;
  localparam int GAIN_W = 5;

  // Register byte addresses
  localparam logic [11:0] CORE2_INPUT_B_OFFSET_TRIM_ADDR = 12'h336;
  localparam logic [11:0] CORE3_INPUT_C_OFFSET_TRIM_ADDR = 12'h338;
  localparam logic [11:0] CORE3_INPUT_D_OFFSET_TRIM_ADDR = 12'h33a;
  localparam logic [11:0] CORE4_OFFSET_TRIM_ADDR = 12'h33c;
  localparam logic [11:0] CORE5_OFFSET_TRIM_ADDR = 12'h33e;
  localparam logic [11:0] CORE0_FINE_TRIM_ADDR = 12'h360;
  localparam logic [11:0] CORE1_FINE_TRIM_ADDR = 12'h361;
  localparam logic [11:0] CORE2_INPUT_A_FINE_TRIM_ADDR = 12'h362;

  // Field positions
  localparam int OFS_LSB = 0;
  localparam int OFS_MSB = 11;
  localparam int OFS_RSV_LSB = 12;
  localparam int OFS_RSV_MSB = 15;
  localparam int GAIN_LSB = 0;
  localparam int GAIN_MSB = 4;
  localparam int GAIN_RSV_LSB = 5;
  localparam int GAIN_RSV_MSB = 7;

  // Printed reset value of the reserved bits
  localparam logic [3:0] OFS_RSV_RESET = 4'h0;
  localparam logic [2:0] GAIN_RSV_RESET = 3'h0;

  // Cycles from reset release until fuse defaults are loaded
  localparam int FUSE_LOAD_CYCLES = 1;

  typedef struct packed {
    logic [11:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } ctrb_bus_req_s;

  typedef struct packed {
    logic [11:0] core2_b;
    logic [11:0] core3_c;
    logic [11:0] core3_d;
    logic [11:0] core4;
    logic [11:0] core5;
  } ctrb_ofs_set_s;

  typedef struct packed {
    logic [4:0] core0;
    logic [4:0] core1;
    logic [4:0] core2_a;
  } ctrb_gain_set_s;

  typedef enum logic [0:0] {
    CTRB_LOAD = 1'b0,
    CTRB_RUN = 1'b1
  } ctrb_state_e;

endpackage

// [ctrb_core_model.sv]
// Converter core model: owns the input routing of cores 2 and 3.
// Assumes routing requests come from the bench right after rising edges.
`timescale 1ns/1ps

module ctrb_core_model (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // Routing requests from the bench
  input wire logic route_b_in,
  input wire logic route_d_in,
  // Routing seen by the trim bank
  output logic core2_sel_b_out,
  output logic core3_sel_d_out
);
  logic sel_b_reg = 1'h0;
  logic sel_d_reg = 1'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Cores switch input on an edge, a cycle late, as a real mux would
  always @(posedge core_clk_in) begin
    sel_b_reg <= rst_in ? 1'h0 : route_b_in;
    sel_d_reg <= rst_in ? 1'h0 : route_d_in;
  end
  assign core2_sel_b_out = sel_b_reg;
  assign core3_sel_d_out = sel_d_reg;
endmodule

// [tb_ctrb_trim_bank.sv]
// Self-checking bench for the trim bank: fuse load, register access, trim routing.
// Assumes the core model drives the routing inputs and fuses change only in reset.
`timescale 1ns/1ps

module tb_ctrb_trim_bank;
  logic core_clk_in = 1'h0;
  logic rst_in = 1'h1;
  logic [11:0] addr_in = 12'h0;
  logic [15:0] wdata_in = 16'h0;
  logic wr_in = 1'h0;
  logic rd_in = 1'h0;
  logic route_b = 1'h0;
  logic route_d = 1'h0;
  logic chk = 1'h0;
  logic rd_d = 1'h0;
  ctrb_pkg::ctrb_ofs_set_s fuse_ofs_in = '0;
  ctrb_pkg::ctrb_gain_set_s fuse_gain_in = '0;
  logic core2_sel_b_in, core3_sel_d_in, core2_gain_en_out, trims_valid_out;
  logic [15:0] rdata_out;
  logic [11:0] core2_offset_out, core3_offset_out, core4_offset_out, core5_offset_out;
  logic [4:0] core0_gain_out, core1_gain_out, core2_gain_out;
  logic [15:0] exp_q[$];
  int idx_q[$];
  int fails = 0;
  int samples_checked = 0;
  logic [15:0] regs [9];
  // Last entry is the unbanked slot next to the core 2 input A gain
  localparam logic [11:0] ADDRS [9] = '{12'h336, 12'h338, 12'h33a, 12'h33c, 12'h33e,
    12'h360, 12'h361, 12'h362, 12'h363};

  always #12.5 core_clk_in = ~core_clk_in;

  ctrb_core_model ctrb_core_model_inst (.core_clk_in(core_clk_in), .rst_in(rst_in),
    .route_b_in(route_b), .route_d_in(route_d), .core2_sel_b_out(core2_sel_b_in),
    .core3_sel_d_out(core3_sel_d_in));

  ctrb_trim_bank ctrb_trim_bank_inst (.core_clk_in(core_clk_in), .rst_in(rst_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .fuse_ofs_in(fuse_ofs_in), .fuse_gain_in(fuse_gain_in), .core2_sel_b_in(core2_sel_b_in),
    .core3_sel_d_in(core3_sel_d_in), .core2_offset_out(core2_offset_out),
    .core3_offset_out(core3_offset_out), .core4_offset_out(core4_offset_out),
    .core5_offset_out(core5_offset_out), .core0_gain_out(core0_gain_out),
    .core1_gain_out(core1_gain_out), .core2_gain_out(core2_gain_out),
    .core2_gain_en_out(core2_gain_en_out), .trims_valid_out(trims_valid_out));

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] obs(input int i);
    case (i)
      1: return 16'(core2_offset_out);
      2: return 16'(core3_offset_out);
      3: return 16'(core4_offset_out);
      4: return 16'(core5_offset_out);
      5: return 16'(core0_gain_out);
      6: return 16'(core1_gain_out);
      7: return 16'(core2_gain_out);
      8: return 16'(core2_gain_en_out);
      9: return 16'(trims_valid_out);
      default: return rdata_out;
    endcase
  endfunction

  // Read data stand only in the cycle after the strobe, so compare there
  always @(posedge core_clk_in) begin
    rd_d <= rd_in;
    if ((rd_d || chk) && exp_q.size() > 0) begin
      samples_checked++;
      if (obs(idx_q[0]) !== exp_q[0]) begin
        fails++;
        $display("ERROR %0t: item %0d got %h expected %h", $time, idx_q[0], obs(idx_q[0]), exp_q[0]);
      end
      void'(exp_q.pop_front());
      void'(idx_q.pop_front());
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Called right after a rising edge; strobes stay up until the next access or idle
  task automatic wr(input int i, input logic [15:0] d);
    addr_in <= ADDRS[i];
    wdata_in <= d;
    wr_in <= 1'h1;
    rd_in <= 1'h0;
    if (i < 8) regs[i] = d;
    @(posedge core_clk_in);
  endtask

  task automatic rd(input int i);
    addr_in <= ADDRS[i];
    wr_in <= 1'h0;
    rd_in <= 1'h1;
    exp_q.push_back(regs[i]);
    idx_q.push_back(0);
    @(posedge core_clk_in);
  endtask

  task automatic idle();
    wr_in <= 1'h0;
    rd_in <= 1'h0;
    @(posedge core_clk_in);
  endtask

  task automatic chk_out(input int i, input logic [15:0] e);
    @(posedge core_clk_in);
    chk <= 1'h1;
    exp_q.push_back(e);
    idx_q.push_back(i);
    @(posedge core_clk_in);
    chk <= 1'h0;
  endtask

  // Model adds one cycle of routing delay, so let two edges pass
  task automatic route(input logic b, input logic d);
    @(posedge core_clk_in);
    route_b <= b;
    route_d <= d;
    repeat (2) @(posedge core_clk_in);
  endtask

  task automatic chk_all();
    chk_out(1, route_b ? regs[0] : 16'h0);
    chk_out(2, route_d ? regs[2] : regs[1]);
    chk_out(3, regs[3]);
    chk_out(4, regs[4]);
    chk_out(5, regs[5]);
    chk_out(6, regs[6]);
    chk_out(7, route_b ? 16'h0 : regs[7]);
    chk_out(8, {15'h0, ~route_b});
    chk_out(9, 16'h1);
  endtask

  // Fresh fuse pattern each reset, so a fixed reset constant cannot pass
  task automatic do_reset();
    rst_in <= 1'h1;
    fuse_ofs_in <= 60'({$urandom, $urandom});
    fuse_gain_in <= 15'($urandom);
    repeat (5) @(posedge core_clk_in);
    rst_in <= 1'h0;
    repeat (3) @(posedge core_clk_in);
    regs = '{16'(fuse_ofs_in.core2_b), 16'(fuse_ofs_in.core3_c), 16'(fuse_ofs_in.core3_d),
      16'(fuse_ofs_in.core4), 16'(fuse_ofs_in.core5), 16'(fuse_gain_in.core0),
      16'(fuse_gain_in.core1), 16'(fuse_gain_in.core2_a), 16'h0};
  endtask

  task automatic end_sim();
    if (exp_q.size() > 0) begin
      fails++;
      $display("ERROR %0t: %0d expected results never seen", $time, exp_q.size());
    end
    if (fails == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4000) @(posedge core_clk_in);
    fails++;
    $display("ERROR %0t: timeout", $time);
    end_sim();
  end

  initial begin
    void'($urandom(94));
    do_reset();
    chk_all();
    for (int i = 0; i < 9; i++) rd(i);
    // No calibration engine here, so offset access is always allowed; reserved bits kept zero
    for (int i = 0; i < 9; i++) wr(i, i < 5 ? 16'h0fff & 16'($urandom) : 16'h001f & 16'($urandom));
    wr(3, 16'h0fff);
    for (int i = 0; i < 9; i++) rd(i);
    // Write then read the same slot with no gap between strobes
    wr(5, 16'h001f & 16'($urandom));
    rd(5);
    wr(2, 16'h0fff & 16'($urandom));
    rd(2);
    idle();
    for (int m = 0; m < 4; m++) begin
      route(m[0], m[1]);
      wr(0, 16'h0fff & 16'($urandom));
      wr(2, 16'h0fff & 16'($urandom));
      idle();
      chk_all();
    end
    do_reset();
    chk_all();
    for (int i = 0; i < 9; i++) rd(i);
    idle();
    // Let the last read data be compared before closing
    repeat (2) @(posedge core_clk_in);
    end_sim();
  end
endmodule
